/* verilog/ddcc_pkg.sv */
// Purpose: Constants and types for the decimation and down-converter configuration block.
// Assumes: APB with 32-bit data; each byte register sits in the low byte of one word.
// Notes: Register indices are byte-register numbers; the bus address is four times the index.
// Contract
// [R1] Chain A enables stages from stage 1; nine stages decimate by 512.
// [R2] Chain A zero bypasses all chain A stages; zero is the reset value.
// [R3] Stage enables are thermometer coded from the lowest usable stage.
// [R4] In down-converter mode chain A starts at stage 3, low bits zero, max 128.
// [R5] Each enabled stage halves the output data rate.
// [R6] Host updates output data and clock rate settings with chain A.
// [R7] Chain B all ones enables stages 3 to 9; 0000-0011 enables stage 3.
// [R8] Chain B 0000-0001 has no effect; zero disables all chain B stages.
// [R9] Chain B acts only on the quadrature channel in down-converter mode.
// [R10] Control one bit 6 picks high-pass (1) or low-pass (0) half-band.
// [R11] The half-band filter also decimates by two.
// [R12] Control one bit 5 enables the first oscillator; reset disabled.
// [R13] Amplitude and phase dithering act only while the generator is enabled.
// [R14] Host should enable both dither forms for best spectrum.
// [R15] Control one bit 2 enables the dither shift register; reset disabled.
// [R16] Control one bit 1 centres output near fs/8; off gives complex I/Q.
// [R17] Host sets bits 0, 2 and 5 together for down-conversion.
// [R18] Control two bit 6 enables the second down-converter stage.
// [R19] Control two bit 5 selects gain two, else unity gain.
// [R20] Tuning word is stored low byte first and resets to zero.
// [R21] Host keeps factory bits at their defaults.
// [R22] Oscillator frequency is tuning word over 2^32 times sample rate.
// [R23] Tuning word, top byte at the next register, acts only with converter one.
// [R24] Host writes only thermometer-coded stage values.
package ddcc_pkg;
  // Byte-register indices
  localparam logic [7:0] IDX_CHAIN_A_LOW = 8'h7A;
  localparam logic [7:0] IDX_CHAIN_A = 8'h7B;
  localparam logic [7:0] IDX_CHAIN_B = 8'h7C;
  localparam logic [7:0] IDX_CTRL_ONE = 8'h80;
  localparam logic [7:0] IDX_CTRL_TWO = 8'h81;
  localparam logic [7:0] IDX_TUNE_LOW = 8'h82;
  localparam logic [7:0] IDX_TUNE_MIDLOW = 8'h83;
  localparam logic [7:0] IDX_TUNE_MIDHIGH = 8'h84;
  localparam logic [7:0] IDX_TUNE_HIGH = 8'h85;
  // Field positions
  localparam int POS_CHAIN_A0 = 6;
  localparam int POS_HB_RESPONSE = 6;
  localparam int POS_OSC_EN = 5;
  localparam int POS_AMP_DITH = 4;
  localparam int POS_PHASE_DITH = 3;
  localparam int POS_PRNG_EN = 2;
  localparam int POS_MIX2_CENTER = 1;
  localparam int POS_DDC1_EN = 0;
  localparam int POS_DDC2_EN = 6;
  localparam int POS_HB_GAIN = 5;
  // Reset values and dither generator constants
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam int DITHER_BITS = 4;
  // Settings carried to the data path as one bundle
  typedef struct packed {
    logic [8:0] stage_en_a;
    logic [8:0] stage_en_b;
    logic [3:0] decim_log2_a;
    logic [3:0] decim_log2_b;
    logic halfband_highpass;
    logic halfband_gain2;
    logic downconv_two_on;
    logic complex_out;
  } ddcc_cfg_type;
endpackage

/* verilog/ddcc_top.sv */
// Purpose: APB register file and control logic for the decimation chains and down-converter.
// Assumes: One 200 MHz core clock, synchronous active-high reset, APB master on the same clock.
// Notes: Read data is captured in the setup cycle, so every access with i_ce high completes with no wait state.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module ddcc_top (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output ddcc_pkg::ddcc_cfg_type o_cfg,
  output logic o_strobe_a,
  output logic o_strobe_b,
  output logic [31:0] o_osc_phase,
  output logic [ddcc_pkg::DITHER_BITS-1:0] o_amp_dither,
  output logic [2:0] o_mix2_phase
);
  import ddcc_pkg::*;

  logic [7:0] chain_a_low;
  logic [7:0] chain_a;
  logic [7:0] chain_b;
  logic [7:0] ctrl_one;
  logic [7:0] ctrl_two;
  logic [7:0] tune_byte [0:3];
  logic [31:0] tune_word;
  logic [31:0] phase_acc;
  logic [15:0] lfsr;
  logic [9:0] rate_cnt;
  logic [8:0] raw_a;
  logic [8:0] eff_a;
  logic [8:0] eff_b;
  logic [3:0] log2_a;
  logic [3:0] log2_b;
  logic [9:0] mask_a;
  logic [9:0] mask_b;
  logic ddc_mode;
  logic acc_on;
  logic prng_on;
  logic setup;
  logic access;
  logic wr_fire;
  logic [7:0] idx;
  logic mapped;

  // Count of enabled stages in a thermometer field
  function automatic logic [3:0] stage_count(input logic [8:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 9; k++) begin
      n = n + {3'h0, v[k]};
    end
    return n;
  endfunction

  // Check that a register index names a defined register; the low two address bits are checked in mapped
  function automatic logic is_reg(input logic [7:0] i);
    return (i == IDX_CHAIN_A_LOW) || (i == IDX_CHAIN_A) || (i == IDX_CHAIN_B) ||
           (i == IDX_CTRL_ONE) || (i == IDX_CTRL_TWO) ||
           (i >= IDX_TUNE_LOW && i <= IDX_TUNE_HIGH);
  endfunction

  // Bus decode
  assign idx = i_paddr[9:2];
  assign mapped = (i_paddr[31:10] == 22'h0) && (i_paddr[1:0] == 2'h0) && is_reg(idx);
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  // A frozen core must not let the master complete a transfer it has not stored
  assign o_pready = access && i_ce;
  assign o_pslverr = access && i_ce && !mapped;
  assign wr_fire = access && i_ce && i_pwrite && mapped;

  // Control and chain registers, full bytes kept so factory bits read back as written
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      chain_a_low <= RST_BYTE; // see [R2]
      chain_a <= RST_BYTE; // see [R2]
      chain_b <= RST_BYTE; // see [R8]
      ctrl_one <= RST_BYTE; // see [R10] see [R12] see [R15]
      ctrl_two <= RST_BYTE; // see [R18] see [R19]
    end else if (wr_fire) begin
      if (idx == IDX_CHAIN_A_LOW) begin
        chain_a_low <= i_pwdata[7:0];
      end
      if (idx == IDX_CHAIN_A) begin
        chain_a <= i_pwdata[7:0];
      end
      if (idx == IDX_CHAIN_B) begin
        chain_b <= i_pwdata[7:0];
      end
      if (idx == IDX_CTRL_ONE) begin
        ctrl_one <= i_pwdata[7:0];
      end
      if (idx == IDX_CTRL_TWO) begin
        ctrl_two <= i_pwdata[7:0];
      end
    end
  end

  // Tuning word bytes, lowest address holds the least significant byte
  generate
    for (genvar g = 0; g < 4; g++) begin : g_tune
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          tune_byte[g] <= RST_BYTE; // see [R20]
        end else if (wr_fire && idx == IDX_TUNE_LOW + 8'(g)) begin
          tune_byte[g] <= i_pwdata[7:0]; // see [R20] see [R23]
        end
      end
    end
  endgenerate
  assign tune_word = {tune_byte[3], tune_byte[2], tune_byte[1], tune_byte[0]};

  // Read data captured in the setup cycle; unmapped reads return zero
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_ce && setup) begin
      o_prdata <= 32'h0000_0000;
      if (mapped && !i_pwrite) begin
        unique case (idx)
          IDX_CHAIN_A_LOW: o_prdata[7:0] <= chain_a_low;
          IDX_CHAIN_A: o_prdata[7:0] <= chain_a;
          IDX_CHAIN_B: o_prdata[7:0] <= chain_b;
          IDX_CTRL_ONE: o_prdata[7:0] <= ctrl_one;
          IDX_CTRL_TWO: o_prdata[7:0] <= ctrl_two;
          default: o_prdata[7:0] <= tune_byte[idx[1:0] - 2'(IDX_TUNE_LOW)];
        endcase
      end
    end
  end

  // Stage enables; patterns other than thermometer codes give undefined rates
  assign ddc_mode = ctrl_one[POS_DDC1_EN];
  assign raw_a = {chain_a, chain_a_low[POS_CHAIN_A0]};
  assign eff_a = ddc_mode ? {raw_a[8:2], 2'b00} : raw_a; // see [R1] see [R4] see [R3]
  // Chain B bit 0 alone enables nothing, so stages 3..9 map to bits 1..7
  assign eff_b = ddc_mode ? {chain_b[7:1], 2'b00} : 9'h000; // see [R7] see [R8] see [R9]
  assign log2_a = stage_count(eff_a);
  assign log2_b = stage_count(eff_b);

  // Configuration bundle handed to the data path
  always_comb begin
    o_cfg.stage_en_a = eff_a;
    o_cfg.stage_en_b = eff_b;
    o_cfg.decim_log2_a = log2_a;
    o_cfg.decim_log2_b = log2_b;
    o_cfg.halfband_highpass = ctrl_one[POS_HB_RESPONSE]; // see [R10]
    o_cfg.halfband_gain2 = ctrl_two[POS_HB_GAIN]; // see [R19]
    o_cfg.downconv_two_on = ctrl_two[POS_DDC2_EN]; // see [R18]
    o_cfg.complex_out = !ctrl_one[POS_MIX2_CENTER]; // see [R16]
  end

  // Output-rate divider: one strobe per 2^stages input samples, plus one more
  // halving from the half-band filter while the down-converter runs
  assign mask_a = 10'((11'h001 << (log2_a + {3'h0, ddc_mode})) - 11'h001); // see [R5] see [R11]
  assign mask_b = 10'((11'h001 << (log2_b + 4'h1)) - 11'h001); // see [R11]
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rate_cnt <= 10'h000;
    end else if (i_ce) begin
      rate_cnt <= rate_cnt + 10'h001;
    end
  end
  assign o_strobe_a = i_ce && ((rate_cnt & mask_a) == mask_a); // see [R5]
  assign o_strobe_b = i_ce && ddc_mode && ((rate_cnt & mask_b) == mask_b); // see [R9]

  // Oscillator accumulator advances by the tuning word each sample
  assign acc_on = ddc_mode && ctrl_one[POS_OSC_EN];
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      phase_acc <= 32'h0000_0000;
    end else if (i_ce && acc_on) begin
      phase_acc <= phase_acc + tune_word; // see [R22] see [R23] see [R12]
    end
  end

  // Dither generator; held still when disabled to save power
  assign prng_on = ctrl_one[POS_PRNG_EN];
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lfsr <= LFSR_SEED;
    end else if (i_ce && prng_on) begin
      lfsr <= lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1); // see [R15]
    end
  end

  // Dithered phase and amplitude noise, both gated by the generator enable
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_osc_phase <= 32'h0000_0000;
      o_amp_dither <= '0;
    end else if (i_ce) begin
      if (prng_on && ctrl_one[POS_PHASE_DITH]) begin
        o_osc_phase <= phase_acc ^ {28'h0000000, lfsr[DITHER_BITS-1:0]}; // see [R13]
      end else begin
        o_osc_phase <= phase_acc;
      end
      if (prng_on && ctrl_one[POS_AMP_DITH]) begin
        o_amp_dither <= lfsr[15 -: DITHER_BITS]; // see [R13]
      end else begin
        o_amp_dither <= '0;
      end
    end
  end

  // Second mixer steps one eighth turn per output sample, giving fs/8 over the rate
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_mix2_phase <= 3'h0;
    end else if (i_ce) begin
      if (!ctrl_one[POS_MIX2_CENTER]) begin
        o_mix2_phase <= 3'h0; // see [R16]
      end else if (o_strobe_a) begin
        o_mix2_phase <= o_mix2_phase + 3'h1; // see [R16]
      end
    end
  end

  a_bypass_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (raw_a == 9'h000) |-> (o_cfg.stage_en_a == 9'h000 && o_cfg.decim_log2_a == 4'h0))
    else $error("chain A zero did not bypass"); // see [R2]
  a_ddc_low_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ddc_mode |-> (o_cfg.stage_en_a[1:0] == 2'b00 && o_cfg.decim_log2_a <= 4'h7))
    else $error("chain A low stages active in down-converter mode"); // see [R4]
  a_chain_b_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !ddc_mode |-> (o_cfg.stage_en_b == 9'h000 && !o_strobe_b))
    else $error("chain B active outside down-converter mode"); // see [R9]
  a_b_lsb_noeffect: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (chain_b == 8'h01) |-> (o_cfg.decim_log2_b == 4'h0))
    else $error("chain B bit 0 changed filtering"); // see [R8]
  a_full_rate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (raw_a == 9'h1FF && !ddc_mode && i_ce) |-> (o_cfg.decim_log2_a == 4'h9))
    else $error("nine stages not counted as 512"); // see [R1]
  a_strobe_halves: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (raw_a == 9'h001 && !ddc_mode && i_ce && o_strobe_a) ##1 (i_ce && $stable(ctrl_one))
      |-> !o_strobe_a)
    else $error("one stage did not halve the rate"); // see [R5]
  a_phase_step: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && acc_on) |=> (phase_acc == $past(phase_acc) + $past(tune_word)))
    else $error("accumulator did not advance by the tuning word"); // see [R22]
  a_phase_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!ddc_mode) |=> $stable(phase_acc))
    else $error("accumulator moved without converter one"); // see [R23]
  a_dither_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!prng_on && i_ce) |=> (o_amp_dither == '0 && o_osc_phase == $past(phase_acc)))
    else $error("dither present with generator off"); // see [R13]
  a_lfsr_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !prng_on |=> $stable(lfsr))
    else $error("shift register ran while disabled"); // see [R15]
  a_tune_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (wr_fire && idx == IDX_TUNE_LOW) |=> (tune_word[7:0] == $past(i_pwdata[7:0])))
    else $error("tuning low byte not stored"); // see [R20]
  a_halfband_sel: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (wr_fire && idx == IDX_CTRL_ONE) |=>
      (o_cfg.halfband_highpass == $past(i_pwdata[POS_HB_RESPONSE])))
    else $error("half-band response select not applied"); // see [R10]
  a_gain_sel: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (wr_fire && idx == IDX_CTRL_TWO) |=>
      (o_cfg.halfband_gain2 == $past(i_pwdata[POS_HB_GAIN]) &&
       o_cfg.downconv_two_on == $past(i_pwdata[POS_DDC2_EN])))
    else $error("control two fields not applied"); // see [R19]

  // Chain B decode end points; bit 0 alone is dropped, so all ones reaches stage 9
  a_chain_b_full: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R7]
    (ddc_mode && chain_b == 8'hFF) |->
      (o_cfg.stage_en_b == 9'h1FC && o_cfg.decim_log2_b == 4'h7))
    else $error("chain B all ones did not enable stages 3 to 9");
  // Lowest chain B setting enables stage 3 alone
  a_chain_b_one: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R7]
    (ddc_mode && chain_b == 8'h03) |->
      (o_cfg.stage_en_b == 9'h004 && o_cfg.decim_log2_b == 4'h1))
    else $error("chain B lowest setting not stage 3 alone");
  // Normal mode passes the full nine-stage field straight through
  a_chain_a_nine: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R1]
    (raw_a == 9'h1FF && !ddc_mode) |-> (o_cfg.stage_en_a == 9'h1FF))
    else $error("chain A nine stages not all enabled");
  // Down-converter mode caps chain A at stages 3 to 9
  a_ddc_max: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R4]
    (raw_a == 9'h1FF && ddc_mode) |->
      (o_cfg.stage_en_a == 9'h1FC && o_cfg.decim_log2_a == 4'h7))
    else $error("chain A not capped at stages 3 to 9");
  // Mixer phase parks at zero while the fs/8 centring is off
  a_mix2_idle: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R16]
    (!ctrl_one[POS_MIX2_CENTER] && i_ce) |=> (o_mix2_phase == 3'h0))
    else $error("second mixer phase moved while centring off");
  // One eighth turn per output sample while centring is on
  a_mix2_step: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R16]
    (ctrl_one[POS_MIX2_CENTER] && i_ce && o_strobe_a) |=>
      (o_mix2_phase == $past(o_mix2_phase) + 3'h1))
    else $error("second mixer phase did not step");
  // With no chain stage the half-band alone still halves the rate
  a_hb_halves: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R11]
    (ddc_mode && raw_a == 9'h000 && i_ce && o_strobe_a) ##1
      (i_ce && $stable(ctrl_one) && $stable(raw_a)) |-> !o_strobe_a)
    else $error("half-band did not decimate by two");
  // Tuning word only changes through its own byte writes
  a_tune_hold: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R20]
    !(wr_fire && idx >= IDX_TUNE_LOW && idx <= IDX_TUNE_HIGH) |=> $stable(tune_word))
    else $error("tuning word changed without a write");
  // Clock enable low freezes every piece of state
  a_ce_freeze: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_ce |=> ($stable(phase_acc) && $stable(lfsr) && $stable(rate_cnt) &&
      $stable(ctrl_one) && $stable(tune_word)))
    else $error("state moved with clock enable low");
  // A running generator never sticks; the seed keeps it off the all-zero state
  a_lfsr_moves: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R15]
    (prng_on && i_ce) |=> (lfsr != $past(lfsr)))
    else $error("shift register stalled while enabled");
  // First oscillator disabled holds its phase
  a_osc_off: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R12]
    !ctrl_one[POS_OSC_EN] |=> $stable(phase_acc))
    else $error("accumulator moved with oscillator disabled");
  // Phase dither touches only the low bits of the phase
  a_phase_dith: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R13]
    (i_ce && prng_on && ctrl_one[POS_PHASE_DITH]) |=>
      (o_osc_phase == ($past(phase_acc) ^ {28'h0000000, $past(lfsr[DITHER_BITS-1:0])})))
    else $error("phase dither not applied");
  // Amplitude dither carries the top generator bits
  a_amp_dith: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [R13]
    (i_ce && prng_on && ctrl_one[POS_AMP_DITH]) |=>
      (o_amp_dither == $past(lfsr[15 -: DITHER_BITS])))
    else $error("amplitude dither not applied");
endmodule

/* verif/ddcc_host_model.sv */
// Purpose: APB host model that programs the configuration block.
// Assumes: Each transfer is started right after a rising edge of i_core_clk.
// Notes: Released address and data turn inverted, so no stale copy can pass for fresh.
`timescale 1ns/1ps
module ddcc_host_model (
  input wire logic i_core_clk,
  input wire logic i_pready,
  input wire logic i_pslverr,
  input wire logic [31:0] i_prdata,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [31:0] o_paddr,
  output logic [31:0] o_pwdata
);
  // Idle bus at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 32'h0;
    o_pwdata = 32'h0;
  end

  // One whole transfer; the request holds until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
    o_psel <= 1'b1;
    o_pwrite <= wr;
    o_paddr <= {22'h0, idx, 2'b00};
    o_pwdata <= {24'h0, d};
    @(posedge i_core_clk);
    o_penable <= 1'b1;
    @(posedge i_core_clk);
    while (i_pready !== 1'b1) @(posedge i_core_clk);
    rd = i_prdata;
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~o_paddr;
    o_pwdata <= ~o_pwdata;
    // Gap edge so a following setup never reassigns psel in this step
    @(posedge i_core_clk);
  endtask
endmodule

/* verif/ddcc_top_tb_top.sv */
// Purpose: Self-checking bench for the decimation and down-converter configuration block.
// Assumes: Host model drives APB; read notes are queued and checked by a monitor.
// Notes: Random register bytes come from a fixed seed.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module ddcc_top_tb_top;
  import ddcc_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, sa, sb, err;
  logic [31:0] paddr, pwdata, prdata, phase, rd, tune;
  ddcc_cfg_type cfg;
  logic [DITHER_BITS-1:0] dith;
  logic [2:0] mix;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [7:0] wv[9];
  // Factory bits stay at zero in random writes
  logic [7:0] fmask[9] = '{8'h40, 8'hFF, 8'hFF, 8'h7F, 8'h60, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] idxs[9] = '{IDX_CHAIN_A_LOW, IDX_CHAIN_A, IDX_CHAIN_B, IDX_CTRL_ONE,
    IDX_CTRL_TWO, IDX_TUNE_LOW, IDX_TUNE_MIDLOW, IDX_TUNE_MIDHIGH, IDX_TUNE_HIGH};
  logic [7:0] bv[4] = '{8'hFF, 8'h03, 8'h01, 8'h00};
  logic [8:0] bs[4] = '{9'h1FC, 9'h004, 9'h000, 9'h000};
  int bl[4] = '{7, 1, 0, 0};
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 10310;
  int nb;

  ddcc_top u_ddcc_top (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_cfg(cfg),
    .o_strobe_a(sa), .o_strobe_b(sb), .o_osc_phase(phase), .o_amp_dither(dith),
    .o_mix2_phase(mix));
  ddcc_host_model u_ddcc_host_model (.i_core_clk(i_core_clk), .i_pready(pready),
    .i_pslverr(pslverr), .i_prdata(prdata), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

  // 200 MHz clock
  always #2.5 i_core_clk = ~i_core_clk;

  // Hang guard, far above the longest expected run
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      final_report();
    end
  end

  // Read results are matched in order against the notes left by the driver
  always @(posedge i_core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      `CHK("prdata", e[31:0], prdata)
      `CHK("pslverr", e[32], pslverr)
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    u_ddcc_host_model.xfer(1'b1, idx, d, rd, err);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] d, input logic bad);
    exp_q.push_back({bad, 24'h0, d});
    u_ddcc_host_model.xfer(1'b0, idx, 8'h00, rd, err);
  endtask

  // Chain A split over two registers; the other bits of the low one stay zero
  task automatic set_a(input logic [8:0] t);
    wr(IDX_CHAIN_A_LOW, {1'b0, t[0], 6'h00});
    wr(IDX_CHAIN_A, t[8:1]);
  endtask

  // Spacing of output strobes; a dead strobe ends the wait at 2000 edges
  task automatic period(input logic b, input int ex);
    int n;
    n = 0;
    @(posedge i_core_clk);
    while ((b ? sb : sa) !== 1'b1 && n < 2000) begin
      @(posedge i_core_clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while ((b ? sb : sa) !== 1'b1 && n < 2000);
    `CHK("strobe period", ex, n)
  endtask

  // Accumulator advance across one settled cycle
  task automatic step_chk(input logic [31:0] ex);
    logic [31:0] p;
    repeat (2) @(posedge i_core_clk);
    #1 p = phase;
    @(posedge i_core_clk);
    #1 `CHK("phase step", ex, phase - p)
    @(posedge i_core_clk);
  endtask

  // Number of dither value changes over 16 cycles
  task automatic dith_moves(output int c);
    logic [DITHER_BITS-1:0] p;
    c = 0;
    // Let the last control write reach the registered output first
    @(posedge i_core_clk);
    p = dith;
    repeat (16) begin
      @(posedge i_core_clk);
      if (dith !== p) c++;
      p = dith;
    end
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    foreach (idxs[k]) rchk(idxs[k], RST_BYTE, 1'b0);
    `CHK("stage a", 9'h000, cfg.stage_en_a)
    `CHK("complex", 1'b1, cfg.complex_out)
    $display("test reset values done");
    foreach (idxs[k]) begin
      wv[k] = 8'($random(seed)) & fmask[k];
      wr(idxs[k], wv[k]);
    end
    foreach (idxs[k]) rchk(idxs[k], wv[k], 1'b0);
    wr(8'h7D, 8'hFF);
    rchk(8'h7D, 8'h00, 1'b1);
    // Clock enable low in the access phase must stall the answer
    fork
      rchk(IDX_TUNE_LOW, wv[5], 1'b0);
      begin
        @(posedge i_core_clk);
        i_ce <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        #1 `CHK("pready stall", 1'b0, pready)
        @(posedge i_core_clk);
        i_ce <= 1'b1;
      end
    join
    $display("test register access done");
    wr(IDX_CTRL_ONE, 8'h00);
    wr(IDX_CTRL_TWO, 8'h00);
    for (int n = 0; n <= 9; n++) begin
      set_a(9'((1 << n) - 1));
      `CHK("stage a", 9'((1 << n) - 1), cfg.stage_en_a)
      `CHK("log2 a", 4'(n), cfg.decim_log2_a)
      period(1'b0, 1 << n);
    end
    wr(IDX_CHAIN_B, 8'hFF);
    nb = 0;
    repeat (600) begin
      @(posedge i_core_clk);
      if (sb !== 1'b0) nb++;
    end
    `CHK("strobe b idle", 0, nb)
    $display("test normal decimation done");
    // Rate settings held elsewhere follow this change; both dithers for best spectrum
    wr(IDX_CTRL_ONE, 8'h3D);
    set_a(9'h1FF);
    `CHK("stage a ddc", 9'h1FC, cfg.stage_en_a)
    `CHK("log2 a ddc", 4'h7, cfg.decim_log2_a)
    period(1'b0, 256);
    foreach (bv[k]) begin
      wr(IDX_CHAIN_B, bv[k]);
      `CHK("stage b", bs[k], cfg.stage_en_b)
      period(1'b1, 1 << (bl[k] + 1));
    end
    dith_moves(nb);
    `CHK("dither runs", 1'b1, nb > 0)
    wr(IDX_CTRL_ONE, 8'h39);
    dith_moves(nb);
    `CHK("dither frozen", 0, nb)
    wr(IDX_CTRL_ONE, 8'h65);
    `CHK("dither off", 4'h0, dith)
    `CHK("hb high", 1'b1, cfg.halfband_highpass)
    `CHK("complex", 1'b1, cfg.complex_out)
    wr(IDX_CTRL_ONE, 8'h03);
    `CHK("complex", 1'b0, cfg.complex_out)
    // Output period is 256 cycles here, so 600 cycles hold two or three steps
    repeat (600) @(posedge i_core_clk);
    `CHK("mix2 steps", 1'b1, mix == 3'h2 || mix == 3'h3)
    wr(IDX_CTRL_TWO, 8'h60);
    `CHK("ddc2 on", 1'b1, cfg.downconv_two_on)
    `CHK("gain two", 1'b1, cfg.halfband_gain2)
    $display("test down-converter mode done");
    tune = $random(seed);
    for (int k = 0; k < 4; k++) wr(IDX_TUNE_LOW + 8'(k), tune[8*k +: 8]);
    wr(IDX_CTRL_ONE, 8'h21);
    step_chk(tune);
    `CHK("mix2 idle", 3'h0, mix)
    wr(IDX_CTRL_ONE, 8'h20);
    step_chk(32'h0);
    wr(IDX_CTRL_ONE, 8'h01);
    step_chk(32'h0);
    $display("test oscillator done");
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    rchk(IDX_TUNE_HIGH, RST_BYTE, 1'b0);
    rchk(IDX_CTRL_ONE, RST_BYTE, 1'b0);
    $display("test second reset done");
    final_report();
  end
endmodule
